/* logic/pita_top.sv */
// Top of the periodic timer array: registers, clock gating, debug halt, channels.
//
// Behaviour
// RULE_01: Clock-off bit stops all timers when 1; it resets to 1.
// RULE_02: Software should clear clock-off before configuring the channels.
// RULE_03: Debug-halt set stops all timers in debug mode; clear keeps them running.
// RULE_04: Enabled timer counts down to zero, then reloads its start value.
// RULE_05: Writing the start value leaves the current count alone until next reload.
// RULE_06: Disable then enable restarts counting from the start value.
// RULE_07: Live-count register reads the counter and is read only.
// RULE_08: Live counts hold while halted in debug mode.
// RULE_09: Interrupt requested while flag set and enable bit is 1.
// RULE_10: Enabling with a pending flag raises the interrupt at once.
// RULE_11: Run bit 0 disables the channel, 1 makes it count.
// RULE_12: Flag set when the counter reaches zero.
// RULE_13: Flag cleared only by writing 1; writing 0 does nothing.
// RULE_14: Each channel drives its own interrupt output.
// RULE_15: Each zero crossing emits a trigger pulse regardless of interrupt enable.
// RULE_16: No new interrupt event until the previous flag is cleared.
// RULE_17: Four channels, each a 16-byte block of four words from 0x100.
// RULE_18: Reserved locations read zero and ignore writes.
// RULE_19: Start value and counter are 32 bits wide.
// RULE_20: Trigger pulse lasts exactly one timer clock cycle.
`timescale 1ns/1ps
module pita_top
  import pita_pkg::*;
(
  input  wire logic                   clk_sys,
  input  wire logic                   rstn,
  input  wire logic [11:0]            reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic [31:0]                 reg_rdata,
  input  wire logic                   debug_mode,
  output logic [pita_pkg::PITA_NCH-1:0] irq,
  output logic [pita_pkg::PITA_NCH-1:0] dma_trigger
);

  // ****************************************
  // Declarations
  // ****************************************
  logic                module_clock_off_reg;
  logic                debug_halt_reg;
  logic [31:0]         rdata_reg;
  logic [31:0]         rdata_next;
  logic                tick_en;
  logic                wr_module;
  logic [PITA_NCH-1:0] wr_start;
  logic [PITA_NCH-1:0] wr_ctrl;
  logic [PITA_NCH-1:0] wr_flag;
  logic                hit_module;
  logic                hit_channel;
  logic [1:0]          ch_sel;
  logic [1:0]          reg_sel;
  logic                rd_ok;
  logic [31:0]         start_count [PITA_NCH];
  logic [31:0]         live_count  [PITA_NCH];
  logic [PITA_NCH-1:0] ch_run;
  logic [PITA_NCH-1:0] ch_ie;
  logic [PITA_NCH-1:0] ch_flag;
  logic [31:0]         mod_word;
  logic [31:0]         ch_word;

  // ****************************************
  // Register decode
  // ****************************************
  pita_regslave u_dec (
    .addr        (reg_addr),
    .wr_en       (reg_wr),
    .rd_en       (reg_rd),
    .wr_module   (wr_module),
    .wr_start    (wr_start),
    .wr_ctrl     (wr_ctrl),
    .wr_flag     (wr_flag),
    .hit_module  (hit_module),
    .hit_channel (hit_channel),
    .ch_sel      (ch_sel),
    .reg_sel     (reg_sel),
    .rd_ok       (rd_ok)
  );

  // Module control register.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      module_clock_off_reg <= PITA_CLK_OFF_RST; // [RULE_01]
      debug_halt_reg       <= PITA_HALT_RST;
    end
    else if (wr_module)
    begin
      module_clock_off_reg <= reg_wdata[PITA_BIT_CLK_OFF];
      debug_halt_reg       <= reg_wdata[PITA_BIT_HALT];
    end
  end

  // Timer clock enable: off when the module is disabled or halted in debug.
  assign tick_en = !module_clock_off_reg
                   && !(debug_halt_reg && debug_mode); // [RULE_01] [RULE_03] [RULE_08]

  // ****************************************
  // Channels
  // ****************************************
  genvar g;
  for (g = 0; g < PITA_NCH; g++)
  begin : g_ch
    pita_channel u_ch (
      .clk_sys           (clk_sys),
      .rstn              (rstn),
      .tick_en           (tick_en),
      .wdata             (reg_wdata),
      .wr_start          (wr_start[g]),
      .wr_ctrl           (wr_ctrl[g]),
      .wr_flag           (wr_flag[g]),
      .start_count       (start_count[g]),
      .live_count        (live_count[g]),
      .channel_run       (ch_run[g]),
      .expiry_irq_enable (ch_ie[g]),
      .expiry_flag       (ch_flag[g]),
      .trigger           (dma_trigger[g]),
      .irq               (irq[g]) // [RULE_14]
    );
  end

  // ****************************************
  // Read path
  // ****************************************
  // Read word selection; unmapped addresses give zero.
  assign mod_word = {30'h00000000, module_clock_off_reg, debug_halt_reg};
  assign ch_word  = (reg_sel == PITA_OFS_START) ? start_count[ch_sel] :
                    (reg_sel == PITA_OFS_LIVE)  ? live_count[ch_sel] : // [RULE_07]
                    (reg_sel == PITA_OFS_CTRL)  ? {30'h00000000, ch_ie[ch_sel], ch_run[ch_sel]} :
                                                  {31'h00000000, ch_flag[ch_sel]};
  assign rdata_next = !rd_ok      ? PITA_ZERO32 : // [RULE_18]
                      hit_module  ? mod_word :
                      ch_word;

  // Read data register, valid only in the cycle after the strobe.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      rdata_reg <= PITA_ZERO32;
    else
      rdata_reg <= rdata_next;
  end

  assign reg_rdata = rdata_reg;

  // Read path and clock gating checks.
  a_clock_off_stops: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE_01]
    module_clock_off_reg |=> $stable(live_count[0]) || $past(wr_ctrl[0]))
    else $error("timer ran with clock off");
  a_debug_halt_holds: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE_03]
    debug_halt_reg && debug_mode && !wr_ctrl[1] |=> $stable(live_count[1]))
    else $error("timer ran in debug halt");
  a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE_18]
    reg_rd && !hit_module && !hit_channel |=> reg_rdata == PITA_ZERO32)
    else $error("reserved read not zero");
  a_idle_rdata_zero: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE_18]
    !reg_rd |=> reg_rdata == PITA_ZERO32)
    else $error("read data stood without a read");
  a_live_read: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE_07]
    rd_ok && !hit_module && reg_sel == PITA_OFS_LIVE
    |=> reg_rdata == $past(live_count[ch_sel]))
    else $error("live count read wrong");

endmodule : pita_top

/* shared/pita_pkg.sv */
// Constants shared by the periodic timer array.
package pita_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int          PITA_NCH          = 4;
  localparam int          PITA_AW           = 12;
  localparam logic [11:0] PITA_MODULE_CONTROL = 12'h000;
  localparam logic [11:0] PITA_CH_BASE      = 12'h100;
  localparam logic [11:0] PITA_CH_END       = 12'h140;
  localparam logic [1:0]  PITA_OFS_START    = 2'h0;
  localparam logic [1:0]  PITA_OFS_LIVE     = 2'h1;
  localparam logic [1:0]  PITA_OFS_CTRL     = 2'h2;
  localparam logic [1:0]  PITA_OFS_FLAG     = 2'h3;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int          PITA_BIT_CLK_OFF  = 1;
  localparam int          PITA_BIT_HALT     = 0;
  localparam int          PITA_BIT_RUN      = 0;
  localparam int          PITA_BIT_IRQ_EN   = 1;
  localparam int          PITA_BIT_EXPIRY   = 0;
  localparam logic        PITA_CLK_OFF_RST  = 1'b1;
  localparam logic        PITA_HALT_RST     = 1'b0;
  localparam logic [31:0] PITA_ZERO32       = 32'h00000000;
  localparam logic [31:0] PITA_ONE32        = 32'h00000001;

endpackage : pita_pkg

/* logic/pita_channel.sv */
// One down-counting timer channel with its start value, control bits and flag.
`timescale 1ns/1ps
module pita_channel
  import pita_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        tick_en,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_start,
  input  wire logic        wr_ctrl,
  input  wire logic        wr_flag,
  output logic [31:0]      start_count,
  output logic [31:0]      live_count,
  output logic             channel_run,
  output logic             expiry_irq_enable,
  output logic             expiry_flag,
  output logic             trigger,
  output logic             irq
);

  logic [31:0] start_reg;
  logic [31:0] count_reg;
  logic        run_reg;
  logic        ie_reg;
  logic        flag_reg;
  logic        trig_reg;
  logic        run_next;
  logic        run_rise;
  logic        expire;
  logic        flag_clr;

  // Decode of control write, expiry and flag clear.
  assign run_next = wdata[PITA_BIT_RUN];
  assign run_rise = wr_ctrl && run_next && !run_reg;
  assign expire   = run_reg && tick_en && (count_reg == PITA_ZERO32);
  assign flag_clr = wr_flag && wdata[PITA_BIT_EXPIRY];

  // Start value register; a write never touches the running count.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      start_reg <= PITA_ZERO32;
    else if (wr_start)
      start_reg <= wdata; // [RULE_05] [RULE_19]
  end

  // Control bits.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      run_reg <= 1'b0;
      ie_reg  <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      run_reg <= run_next; // [RULE_11]
      ie_reg  <= wdata[PITA_BIT_IRQ_EN];
    end
  end

  // Down-counter: loads on enable, reloads at zero, counts on each tick.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      count_reg <= PITA_ZERO32;
    else if (run_rise)
      count_reg <= start_reg; // [RULE_06] [RULE_11]
    else if (expire)
      count_reg <= start_reg; // [RULE_04]
    else if (run_reg && tick_en)
      count_reg <= count_reg - PITA_ONE32; // [RULE_04] [RULE_08]
  end

  // Expiry flag: set wins over a clear in the same cycle.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      flag_reg <= 1'b0;
    else if (expire)
      flag_reg <= 1'b1; // [RULE_12]
    else if (flag_clr)
      flag_reg <= 1'b0; // [RULE_13]
  end

  // Trigger pulse, one cycle per expiry.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      trig_reg <= 1'b0;
    else
      trig_reg <= expire; // [RULE_15] [RULE_20]
  end

  // Outputs.
  assign start_count       = start_reg;
  assign live_count        = count_reg; // [RULE_07]
  assign channel_run       = run_reg;
  assign expiry_irq_enable = ie_reg;
  assign expiry_flag       = flag_reg;
  assign trigger           = trig_reg;
  assign irq               = flag_reg && ie_reg; // [RULE_09] [RULE_10] [RULE_16]

  a_trig_one_cycle: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE_20]
    trigger |=> !trigger) else $error("trigger longer than one cycle");
  a_expiry_sets_flag: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE_12]
    expire |=> expiry_flag && trigger) else $error("expiry lost");
  a_flag_w0_keeps: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE_13]
    expiry_flag && !flag_clr |=> expiry_flag) else $error("flag dropped");
  a_irq_masked: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE_09]
    !expiry_irq_enable |-> !irq) else $error("masked irq raised");
  a_reload_zero: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE_04]
    expire && !wr_ctrl |=> live_count == $past(start_reg)) else $error("no reload");
  a_hold_no_tick: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE_08]
    !tick_en && !run_rise |=> $stable(live_count)) else $error("count moved");
  a_start_no_disturb: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE_05]
    wr_start && run_reg && tick_en && count_reg != PITA_ZERO32 && !wr_ctrl
    |=> live_count == $past(count_reg) - PITA_ONE32) else $error("count disturbed");
  a_enable_loads: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE_06]
    run_rise |=> live_count == $past(start_reg)) else $error("no load on enable");

endmodule : pita_channel

/* logic/pita_regslave.sv */
// Register port decode for the periodic timer array.
`timescale 1ns/1ps
module pita_regslave
  import pita_pkg::*;
(
  input  wire logic [11:0]         addr,
  input  wire logic                wr_en,
  input  wire logic                rd_en,
  output logic                     wr_module,
  output logic [PITA_NCH-1:0]      wr_start,
  output logic [PITA_NCH-1:0]      wr_ctrl,
  output logic [PITA_NCH-1:0]      wr_flag,
  output logic                     hit_module,
  output logic                     hit_channel,
  output logic [1:0]               ch_sel,
  output logic [1:0]               reg_sel,
  output logic                     rd_ok
);

  logic [11:0] ch_rel;

  // Word-aligned decode of the module and channel blocks.
  assign ch_rel      = addr - PITA_CH_BASE;
  assign hit_module  = (addr == PITA_MODULE_CONTROL);
  assign hit_channel = (addr >= PITA_CH_BASE) && (addr < PITA_CH_END)
                       && (addr[1:0] == 2'h0); // [RULE_17]
  assign ch_sel      = ch_rel[5:4];
  assign reg_sel     = ch_rel[3:2];
  assign rd_ok       = rd_en && (hit_module || hit_channel); // [RULE_18]
  assign wr_module   = wr_en && hit_module;

  // Per-channel write strobes; the live count is read only.
  genvar g;
  for (g = 0; g < PITA_NCH; g++)
  begin : g_wr
    logic sel;
    assign sel         = wr_en && hit_channel && (ch_sel == 2'(g));
    assign wr_start[g] = sel && (reg_sel == PITA_OFS_START);
    assign wr_ctrl[g]  = sel && (reg_sel == PITA_OFS_CTRL);
    assign wr_flag[g]  = sel && (reg_sel == PITA_OFS_FLAG); // [RULE_07]
  end

endmodule : pita_regslave

/* verification/pita_sink.sv */
// Trigger sink that stands in for the DMA side of the timer array.
`timescale 1ns/1ps
module pita_sink
(
  input  wire logic [pita_pkg::PITA_NCH-1:0] dma_trigger,
  input  wire logic                          clk_sys,
  input  wire logic                          rstn,
  output logic [15:0]                        n_pulse
);
  import pita_pkg::*;
  logic [PITA_NCH-1:0] trig_d;

  // Counts each trigger by its rising edge, every channel line apart.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      trig_d  <= '0;
      n_pulse <= 16'h0000;
    end
    else
    begin
      trig_d  <= dma_trigger;
      n_pulse <= n_pulse + 16'($countones(dma_trigger & ~trig_d));
    end
  end
endmodule : pita_sink

/* verification/tb_periodic_interrupt_timer_array.sv */
// Self-checking bench for the periodic timer array with a reference model.
`timescale 1ns/1ps
module tb_periodic_interrupt_timer_array;
  import pita_pkg::*;
  logic                clk_sys, rstn, reg_wr, reg_rd, debug_mode, m_off, m_halt, rd_d;
  logic [11:0]         reg_addr;
  logic [31:0]         reg_wdata, reg_rdata, k;
  logic [PITA_NCH-1:0] irq, dma_trigger, m_run, m_ie, m_flag, m_trig;
  logic [15:0]         n_pulse, m_np;
  logic [31:0]         m_start [PITA_NCH];
  logic [31:0]         m_cnt [PITA_NCH];
  logic [31:0]         exp_q [$];
  logic [11:0]         ra [10] = '{12'h000, 12'h004, 12'h0FC, 12'h100, 12'h102, 12'h104,
                                   12'h108, 12'h10C, 12'h140, 12'h1FC};
  int                  n_errors, n_compared, cyc;
  integer              seed = 32'h66cb51e2;

  pita_top i_pita_top (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .debug_mode(debug_mode), .irq(irq), .dma_trigger(dma_trigger));
  pita_sink i_pita_sink (.dma_trigger(dma_trigger), .clk_sys(clk_sys), .rstn(rstn),
    .n_pulse(n_pulse));

  // Clock at 50 MHz.
  initial clk_sys = 1'b0;
  always #10 clk_sys = ~clk_sys;

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, e, s);
    end
  endtask : chk

  // One bus cycle; every signal is set once per edge, so strobes may run back to back.
  task automatic bus(input logic w, input logic r, input logic [11:0] a, input logic [31:0] d);
    reg_wr    <= w;
    reg_rd    <= r;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
  endtask : bus

  task automatic wrap_up;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up

  function automatic logic [31:0] rd_exp(input logic [11:0] a);
    logic [1:0] c;
    c = a[5:4];
    rd_exp = 32'h00000000;
    if (a == PITA_MODULE_CONTROL)
      rd_exp = {30'h0, m_off, m_halt};
    else if (a >= PITA_CH_BASE && a < PITA_CH_END && a[1:0] == 2'h0)
      case (a[3:2])
        PITA_OFS_START: rd_exp = m_start[c];
        PITA_OFS_LIVE:  rd_exp = m_cnt[c];
        PITA_OFS_CTRL:  rd_exp = {30'h0, m_ie[c], m_run[c]};
        default:        rd_exp = {31'h0, m_flag[c]};
      endcase
  endfunction : rd_exp

  // ****************************************
  // Reference model and monitor
  // ****************************************
  // Mirrors the registers edge by edge; read notes are queued at the read edge.
  always @(posedge clk_sys or negedge rstn)
  begin : model
    logic tick;
    logic sel;
    if (!rstn)
    begin
      {m_off, m_halt, m_run, m_ie, m_flag, m_trig, m_np, rd_d} = '0;
      m_off = 1'b1;
      foreach (m_cnt[i])
      begin
        m_cnt[i] = '0;
        m_start[i] = '0;
      end
    end
    else
    begin
      rd_d = reg_rd;
      if (reg_rd)
        exp_q.push_back(rd_exp(reg_addr));
      tick = !m_off && !(m_halt && debug_mode);
      sel = reg_wr && reg_addr >= PITA_CH_BASE && reg_addr < PITA_CH_END && reg_addr[1:0] == 2'h0;
      m_trig = '0;
      for (int i = 0; i < PITA_NCH; i++)
      begin
        if (m_run[i] && tick)
          if (m_cnt[i] == 0)
          begin
            {m_cnt[i], m_flag[i], m_trig[i]} = {m_start[i], 2'b11};
            m_np++;
          end
          else
            m_cnt[i]--;
        if (sel && reg_addr[5:4] == i[1:0])
          case (reg_addr[3:2])
            PITA_OFS_START: m_start[i] = reg_wdata;
            PITA_OFS_CTRL:
            begin
              if (!m_run[i] && reg_wdata[0])
                m_cnt[i] = m_start[i];
              {m_ie[i], m_run[i]} = reg_wdata[1:0];
            end
            PITA_OFS_FLAG: if (reg_wdata[0] && !m_trig[i]) m_flag[i] = 1'b0;
            default: ;
          endcase
      end
      if (reg_wr && reg_addr == PITA_MODULE_CONTROL)
        {m_off, m_halt} = reg_wdata[1:0];
    end
  end

  // Compares read data, interrupt lines and triggers once they have settled.
  always @(negedge clk_sys)
    if (rstn)
    begin
      if (rd_d)
        chk("read data", exp_q.pop_front(), reg_rdata);
      else
        chk("idle read data", PITA_ZERO32, reg_rdata);
      chk("irq", {28'h0, m_flag & m_ie}, {28'h0, irq});
      chk("trigger", {28'h0, m_trig}, {28'h0, dma_trigger});
    end

  // Cuts a hang short.
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_errors++;
      wrap_up();
    end
  end

  // ****************************************
  // Stimulus
  // ****************************************
  initial
  begin
    {reg_wr, reg_rd, reg_addr, reg_wdata, debug_mode, rstn} = '0;
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    bus(1'b1, 1'b0, 12'h004, 32'hFFFFFFFF);
    bus(1'b1, 1'b0, 12'h140, 32'hFFFFFFFF);
    bus(1'b1, 1'b0, 12'h101, 32'hFFFFFFFF);
    foreach (ra[i]) bus(1'b0, 1'b1, ra[i], 32'h0);
    bus(1'b1, 1'b0, PITA_MODULE_CONTROL, 32'h0);
    for (int i = 0; i < PITA_NCH; i++)
    begin
      bus(1'b1, 1'b0, PITA_CH_BASE + 12'(i * 16), 32'(i + 2));
      bus(1'b1, 1'b0, PITA_CH_BASE + 12'(i * 16 + 8), {30'h0, i[0], 1'b1});
    end
    repeat (300)
    begin
      k = $random(seed);
      bus(k[9], !k[9] && !k[8], PITA_CH_BASE + {6'h0, k[3:0], 2'b00},
          k[3:2] == 2'h0 ? 32'(k[12:10]) + 32'h2 : $random(seed));
    end
    // Restart every channel so that the halt scenarios see running counters.
    for (int i = 0; i < PITA_NCH; i++)
    begin
      bus(1'b1, 1'b0, PITA_CH_BASE + 12'(i * 16 + 8), 32'h0);
      bus(1'b1, 1'b0, PITA_CH_BASE + 12'(i * 16 + 8), {30'h0, i[0], 1'b1});
    end
    bus(1'b1, 1'b0, PITA_MODULE_CONTROL, 32'h1);
    debug_mode <= 1'b1;
    for (int j = 0; j < 12; j++)
      bus(1'b0, j[0], PITA_CH_BASE + 12'(j * 4) & 12'h13C | 12'h4, 32'h0);
    bus(1'b1, 1'b0, PITA_MODULE_CONTROL, 32'h0);
    repeat (20) bus(1'b0, 1'b1, 12'h104, 32'h0);
    debug_mode <= 1'b0;
    bus(1'b1, 1'b0, PITA_MODULE_CONTROL, 32'h2);
    repeat (12) bus(1'b0, 1'b1, 12'h114, 32'h0);
    bus(1'b1, 1'b0, PITA_MODULE_CONTROL, 32'h0);
    bus(1'b1, 1'b0, 12'h100, 32'h2);
    bus(1'b1, 1'b0, 12'h108, 32'h1);
    repeat (12) bus(1'b0, 1'b0, 12'h0, 32'h0);
    bus(1'b1, 1'b0, 12'h108, 32'h3);
    bus(1'b1, 1'b0, 12'h10C, 32'h0);
    bus(1'b1, 1'b0, 12'h10C, 32'h1);
    repeat (6) bus(1'b0, 1'b1, 12'h10C, 32'h0);
    // Stop the timers and let the last trigger reach the sink before counting.
    bus(1'b1, 1'b0, PITA_MODULE_CONTROL, 32'h2);
    repeat (2) bus(1'b0, 1'b0, 12'h0, 32'h0);
    @(negedge clk_sys);
    chk("pulses", {16'h0, m_np}, {16'h0, n_pulse});
    wrap_up();
  end
endmodule : tb_periodic_interrupt_timer_array
